// ### hdl/sgpc_card.sv
// Generator card end: control shifter, waveform memory and playback.
`timescale 1ns/1ps
module sgpc_card
  import sgpc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  sgpc_link_if.card link,
  output logic [SAMPLE_W-1:0] converter_word_o,
  output logic deglitch_sample_strobe_o,
  output logic [3:0] filter_range_code_o,
  output logic [2:0] amp_gain_code_o,
  output logic [7:0] output_offset_value_o,
  output logic [7:0] converter_reference_value_o,
  output logic [ADDR_W-1:0] play_address_o,
  output logic scan_active_o
);
  logic [2:0] dat_sync_reg, shf_sync_reg, lat_sync_reg, gck_sync_reg;
  logic [CTRL_BITS-1:0] shift_reg;
  logic [CTRL_BITS-1:0] ctrl_reg;
  logic ctrl_new_reg;
  logic [SAMPLE_W-1:0] mem_lo [BLOCK_WORDS];
  logic [SAMPLE_W-1:0] mem_hi [BLOCK_WORDS];
  logic [SAMPLE_W-1:0] rd_lo_reg, rd_hi_reg;
  logic rd_sel_reg, rd_valid_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic tick;
  sgpc_mode_type mode_reg, mode_next;
  logic loading;
  logic [ADDR_W-1:0] mask;
  logic single_mode, run_bit, clr_bit, trig_bit, wave_hit;

  // Second stage feeds the third only for edge detection, keeping stage one isolated.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dat_sync_reg <= 3'h0;
      shf_sync_reg <= 3'h0;
      lat_sync_reg <= 3'h0;
      gck_sync_reg <= 3'h0;
    end else begin
      dat_sync_reg <= {dat_sync_reg[1:0], link.ser_data};
      shf_sync_reg <= {shf_sync_reg[1:0], link.ser_shift};
      lat_sync_reg <= {lat_sync_reg[1:0], link.ser_latch};
      gck_sync_reg <= {gck_sync_reg[1:0], link.generator_clock};
    end
  end

  // Bits shift in MSB first; the frame is copied only on the latch edge.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      shift_reg <= CTRL_ZERO;
      // An all-zero word would jump the filter to its top range right after reset.
      ctrl_reg <= CTRL_RESET;
      ctrl_new_reg <= 1'b0;
    end else begin
      ctrl_new_reg <= 1'b0;
      if (shf_sync_reg[1] && !shf_sync_reg[2]) begin
        shift_reg <= {shift_reg[CTRL_BITS-2:0], dat_sync_reg[1]};
      end
      if (lat_sync_reg[1] && !lat_sync_reg[2]) begin
        ctrl_reg <= shift_reg;
        ctrl_new_reg <= 1'b1;
      end
    end
  end

  assign single_mode = ctrl_reg[SINGLE_LSB];
  assign run_bit = ctrl_reg[RUN_LSB];
  assign clr_bit = ctrl_reg[CLR_LSB];
  assign trig_bit = ctrl_reg[TRIG_LSB];
  assign mask = sgpc_ring_mask(ctrl_reg[SIZE_LSB +: 4]);
  assign wave_hit = link.wave_strobe && (link.wave_addr == WAVE_PORT_ADDR);
  // Wave strobe and data come from logic on this clock, so no synchroniser.
  assign loading = wave_hit;

  // Divider reloads from the divisor; zero divisor treated as one.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_cnt_reg <= DIV_ZERO;
    end else if (gck_sync_reg[1] && !gck_sync_reg[2]) begin
      if (div_cnt_reg <= DIV_ONE) begin
        div_cnt_reg <= ctrl_reg[DIV_LSB +: DIV_W];
      end else begin
        div_cnt_reg <= div_cnt_reg - DIV_ONE;
      end
    end
  end
  assign tick = gck_sync_reg[1] && !gck_sync_reg[2] && (div_cnt_reg <= DIV_ONE);

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      SGPC_CPU: begin
        if (!loading && run_bit && !single_mode) mode_next = SGPC_SCAN;
        else if (!loading && run_bit && single_mode) mode_next = SGPC_PARK;
      end
      SGPC_SCAN: begin
        if (loading || !run_bit) mode_next = SGPC_CPU;
        else if (ctrl_new_reg && single_mode) mode_next = SGPC_PARK;
        else if (single_mode && tick && ((addr_reg & mask) == mask)) mode_next = SGPC_PARK;
      end
      SGPC_PARK: begin
        if (loading || !run_bit) mode_next = SGPC_CPU;
        else if (!single_mode) mode_next = SGPC_SCAN;
        else if (ctrl_new_reg && trig_bit) mode_next = SGPC_SCAN;
      end
      default: mode_next = SGPC_CPU;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mode_reg <= SGPC_CPU;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // One address counter serves both loading and scanning.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      addr_reg <= ADDR_ZERO;
    end else if (loading) begin
      addr_reg <= addr_reg + ADDR_ONE;
    end else if ((ctrl_new_reg && clr_bit) || (mode_reg != SGPC_SCAN && mode_next != SGPC_CPU)) begin
      addr_reg <= ADDR_ZERO;
    end else if (mode_reg == SGPC_SCAN && tick) begin
      addr_reg <= (addr_reg + ADDR_ONE) & mask;
    end
  end

  // Block select is the top address bit.
  always_ff @(posedge core_clk_i) begin
    if (loading) begin
      if (addr_reg[ADDR_W-1]) begin
        mem_hi[addr_reg[ADDR_W-2:0]] <= link.wave_word[SAMPLE_W-1:0];
      end else begin
        mem_lo[addr_reg[ADDR_W-2:0]] <= link.wave_word[SAMPLE_W-1:0];
      end
    end
    rd_lo_reg <= mem_lo[addr_reg[ADDR_W-2:0]];
    rd_hi_reg <= mem_hi[addr_reg[ADDR_W-2:0]];
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_sel_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_sel_reg <= addr_reg[ADDR_W-1];
      rd_valid_reg <= (mode_reg != SGPC_CPU) && tick;
    end
  end

  // Strobe goes low for the cycle the new word lands so the stage holds.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      converter_word_o <= SAMPLE_ZERO;
      deglitch_sample_strobe_o <= 1'b0;
    end else if (mode_reg == SGPC_CPU) begin
      converter_word_o <= SAMPLE_ZERO;
      deglitch_sample_strobe_o <= 1'b1;
    end else if (rd_valid_reg) begin
      converter_word_o <= rd_sel_reg ? rd_hi_reg : rd_lo_reg;
      deglitch_sample_strobe_o <= 1'b0;
    end else begin
      deglitch_sample_strobe_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      filter_range_code_o <= FLT_20HZ;
      amp_gain_code_o <= GAIN_0DB;
      output_offset_value_o <= BYTE_ZERO;
      converter_reference_value_o <= BYTE_ZERO;
      play_address_o <= ADDR_ZERO;
      scan_active_o <= 1'b0;
    end else begin
      if (ctrl_reg[OFF_LSB] || ctrl_reg[DC_LSB]) begin
        filter_range_code_o <= FLT_20HZ;
      end else begin
        filter_range_code_o <= ctrl_reg[FLT_LSB +: 4];
      end
      amp_gain_code_o <= ctrl_reg[GAIN_LSB +: 3];
      output_offset_value_o <= ctrl_reg[OFS_LSB +: 8];
      converter_reference_value_o <= ctrl_reg[REF_LSB +: 8];
      play_address_o <= addr_reg;
      scan_active_o <= (mode_reg == SGPC_SCAN);
    end
  end
endmodule : sgpc_card

// ### hdl/sgpc_pkg.sv
// Shared constants and types for the signal generator playback control link.
package sgpc_pkg;
  localparam int CTRL_BITS = 48;
  localparam int SAMPLE_W = 12;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 19;
  localparam int DIV_W = 15;
  localparam int MEM_WORDS = 524288;
  localparam int BLOCK_WORDS = 262144;
  // Control word field positions, least significant bit of each field.
  localparam int REF_LSB = 0;
  localparam int OFS_LSB = 8;
  localparam int FLT_LSB = 16;
  localparam int GAIN_LSB = 20;
  localparam int SIZE_LSB = 23;
  localparam int CLR_LSB = 27;
  localparam int RUN_LSB = 28;
  localparam int DIV_LSB = 29;
  localparam int SINGLE_LSB = 44;
  localparam int DC_LSB = 45;
  localparam int OFF_LSB = 46;
  localparam int TRIG_LSB = 47;
  localparam logic [3:0] FLT_20HZ = 4'hd;
  localparam logic [3:0] FLT_100KHZ = 4'h0;
  localparam logic [2:0] GAIN_0DB = 3'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] SAMPLE_ZERO = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 19'h00000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 19'h00001;
  localparam logic [DIV_W-1:0] DIV_ZERO = 15'h0000;
  localparam logic [DIV_W-1:0] DIV_ONE = 15'h0001;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_ONE = 6'h01;
  localparam logic [5:0] CNT_LAST = 6'h2f;
  localparam logic [CTRL_BITS-1:0] CTRL_ZERO = 48'h000000000000;
  // Control word after reset: generator off and 0 dB gain, matching the output reset values.
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 48'h400000100000;
  localparam logic [23:0] WAVE_PORT_ADDR = 24'h00fff0;
  // Software port offsets of the host controller.
  localparam logic [3:0] HOST_CTRL_LO = 4'h0;
  localparam logic [3:0] HOST_CTRL_HI = 4'h1;
  localparam logic [3:0] HOST_WAVE = 4'h2;
  localparam logic [3:0] HOST_STATUS = 4'h3;
  localparam logic [3:0] HOST_CTRL_MID = 4'h4;
  typedef enum logic [2:0] {
    SGPC_CPU = 3'b001,
    SGPC_SCAN = 3'b010,
    SGPC_PARK = 3'b100
  } sgpc_mode_type;
  // Ring length mask: code bit 0 is the lowest weight of the doubling.
  function automatic logic [ADDR_W-1:0] sgpc_ring_mask(input logic [3:0] code);
    logic [3:0] n;
    n = code;
    if (n[3] && n[2]) begin
      n = n - 4'h4;
    end
    return ADDR_W'((32'h100 << n) - 32'h1);
  endfunction : sgpc_ring_mask
endpackage : sgpc_pkg

// ### hdl/sgpc_link_if.sv
// Link between the main board controller and the generator card.
`timescale 1ns/1ps
interface sgpc_link_if;
  import sgpc_pkg::*;
  logic ser_data;
  logic ser_shift;
  logic ser_latch;
  logic [WORD_W-1:0] wave_word;
  logic wave_strobe;
  logic [23:0] wave_addr;
  logic generator_clock;
  modport card (
    input ser_data,
    input ser_shift,
    input ser_latch,
    input wave_word,
    input wave_strobe,
    input wave_addr,
    input generator_clock
  );
  modport board (
    output ser_data,
    output ser_shift,
    output ser_latch,
    output wave_word,
    output wave_strobe,
    output wave_addr,
    output generator_clock
  );
endinterface : sgpc_link_if

// ### hdl/sgpc_board.sv
// Main board end: software port, serial control sender, waveform writer.
`timescale 1ns/1ps
module sgpc_board
  import sgpc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  sgpc_link_if.board link,
  input wire logic gen_clk_src_i,
  input wire logic [3:0] sw_addr_i,
  input wire logic [WORD_W-1:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [WORD_W-1:0] sw_rdata_o
);
  logic [CTRL_BITS-1:0] stage_reg, send_reg;
  logic [5:0] bit_cnt_reg;
  logic busy_reg, phase_reg;
  logic ser_data_reg, ser_shift_reg, ser_latch_reg;
  logic [WORD_W-1:0] word_reg;
  logic wstb_reg;
  logic [31:0] wave_count_reg;

  // Writing the high part starts a send of the staged 48-bit frame.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      stage_reg <= CTRL_ZERO;
    end else if (sw_wr_i && sw_addr_i == HOST_CTRL_LO) begin
      stage_reg[15:0] <= sw_wdata_i;
    end else if (sw_wr_i && sw_addr_i == HOST_CTRL_MID) begin
      stage_reg[31:16] <= sw_wdata_i;
    end else if (sw_wr_i && sw_addr_i == HOST_CTRL_HI) begin
      stage_reg[47:32] <= sw_wdata_i;
    end
  end

  // Each bit holds two cycles low and two high so the card's sampler sees it.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      busy_reg <= 1'b0;
      phase_reg <= 1'b0;
      bit_cnt_reg <= CNT_ZERO;
      send_reg <= CTRL_ZERO;
      ser_data_reg <= 1'b0;
      ser_shift_reg <= 1'b0;
      ser_latch_reg <= 1'b0;
    end else if (!busy_reg) begin
      ser_latch_reg <= 1'b0;
      ser_shift_reg <= 1'b0;
      if (sw_wr_i && sw_addr_i == HOST_CTRL_HI) begin
        busy_reg <= 1'b1;
        send_reg <= {sw_wdata_i, stage_reg[31:0]};
        bit_cnt_reg <= CNT_ZERO;
        phase_reg <= 1'b0;
      end
    end else begin
      phase_reg <= ~phase_reg;
      if (!phase_reg) begin
        if (!ser_shift_reg) begin
          ser_data_reg <= send_reg[CTRL_BITS-1];
        end
      end else if (ser_latch_reg) begin
        ser_latch_reg <= 1'b0;
        busy_reg <= 1'b0;
      end else if (!ser_shift_reg) begin
        ser_shift_reg <= 1'b1;
      end else begin
        ser_shift_reg <= 1'b0;
        send_reg <= {send_reg[CTRL_BITS-2:0], 1'b0};
        bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
        if (bit_cnt_reg == CNT_LAST) ser_latch_reg <= 1'b1;
      end
    end
  end

  // Every word goes to the one fixed port address; the card steps its own address.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      word_reg <= 16'h0000;
      wstb_reg <= 1'b0;
      wave_count_reg <= 32'h0;
    end else begin
      wstb_reg <= sw_wr_i && sw_addr_i == HOST_WAVE;
      if (sw_wr_i && sw_addr_i == HOST_WAVE) begin
        word_reg <= sw_wdata_i;
        wave_count_reg <= wave_count_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sw_rdata_o <= 16'h0000;
    end else if (sw_rd_i && sw_addr_i == HOST_STATUS) begin
      sw_rdata_o <= {busy_reg, wave_count_reg[14:0]};
    end else begin
      sw_rdata_o <= 16'h0000;
    end
  end

  assign link.ser_data = ser_data_reg;
  assign link.ser_shift = ser_shift_reg;
  assign link.ser_latch = ser_latch_reg;
  assign link.wave_word = word_reg;
  assign link.wave_strobe = wstb_reg;
  assign link.wave_addr = WAVE_PORT_ADDR;
  assign link.generator_clock = gen_clk_src_i;
endmodule : sgpc_board

// ### bench/sgpc_checker.sv
// Concurrent checks on the control link and the card outputs.
`timescale 1ns/1ps
module sgpc_checker
  import sgpc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ser_data,
  input wire logic ser_shift,
  input wire logic ser_latch,
  input wire logic wave_strobe,
  input wire logic [23:0] wave_addr,
  input wire logic [SAMPLE_W-1:0] converter_word_o,
  input wire logic deglitch_sample_strobe_o,
  input wire logic [3:0] filter_range_code_o,
  input wire logic [2:0] amp_gain_code_o,
  input wire logic [7:0] output_offset_value_o,
  input wire logic [7:0] converter_reference_value_o,
  input wire logic [ADDR_W-1:0] play_address_o,
  input wire logic scan_active_o
);
  logic [47:0] shift_reg;
  logic [47:0] frame_reg;
  logic [5:0] bit_cnt_reg;
  logic [7:0] latch_hist_reg;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Mirror of the card's shifter so field checks need no knowledge of the card's insides.
  always_ff @(posedge core_clk_i) begin
    if ($rose(ser_shift)) shift_reg <= {shift_reg[46:0], ser_data};
  end
  always_ff @(posedge core_clk_i) begin
    if ($rose(ser_latch)) frame_reg <= shift_reg;
  end
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || $rose(ser_latch)) bit_cnt_reg <= CNT_ZERO;
    else if ($rose(ser_shift)) bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
  end
  always_ff @(posedge core_clk_i) begin
    latch_hist_reg <= {latch_hist_reg[6:0], ser_latch};
  end
  wave_port_a: assert property (wave_strobe |-> wave_addr == WAVE_PORT_ADDR)
    else $error("waveform strobe off the data port address");
  frame_len_a: assert property ($rose(ser_latch) |-> bit_cnt_reg == 6'h30)
    else $error("control frame not 48 bits long");
  data_stable_a: assert property (ser_shift && $past(ser_shift) |-> $stable(ser_data))
    else $error("serial data moved during shift");
  load_zero_a: assert property (wave_strobe |-> ##[1:4] converter_word_o == SAMPLE_ZERO)
    else $error("converter not cleared while loading");
  level_load_a: assert property ($rose(ser_latch) |-> ##6
    converter_reference_value_o == frame_reg[7:0] && output_offset_value_o == frame_reg[15:8])
    else $error("reference or offset differs from frame");
  filter_load_a: assert property ($rose(ser_latch) |-> ##6 filter_range_code_o ==
    ((frame_reg[DC_LSB] || frame_reg[OFF_LSB]) ? FLT_20HZ : frame_reg[FLT_LSB+:4]))
    else $error("filter code differs from frame");
  gain_load_a: assert property ($rose(ser_latch) |-> ##6 amp_gain_code_o == frame_reg[GAIN_LSB+:3])
    else $error("gain code differs from frame");
  frame_hold_a: assert property (!$stable({converter_reference_value_o, output_offset_value_o,
    filter_range_code_o, amp_gain_code_o}) |-> |latch_hist_reg)
    else $error("control output moved without a frame");
  addr_step_a: assert property (scan_active_o && $past(scan_active_o) && !$stable(play_address_o)
    && play_address_o != ADDR_ZERO |-> play_address_o == $past(play_address_o) + ADDR_ONE)
    else $error("scan address skipped");
  glitch_hold_a: assert property (scan_active_o && !$stable(converter_word_o)
    |-> !deglitch_sample_strobe_o)
    else $error("strobe high while converter word changes");
  strobe_pulse_a: assert property ($fell(deglitch_sample_strobe_o) && scan_active_o
    |=> deglitch_sample_strobe_o)
    else $error("hold phase longer than one cycle");
  cover property ($rose(ser_latch));
  cover property (wave_strobe);
  cover property (scan_active_o && play_address_o == ADDR_ZERO && $past(play_address_o) != ADDR_ZERO);
endmodule : sgpc_checker

// ### bench/testbench.sv
// Board and card joined back to back, driven through the software port.
`timescale 1ns/1ps
module testbench;
  import sgpc_pkg::*;
  logic clk, rst, gen_clk, sw_wr, sw_rd, strobe, scan, chk_scan, rd_d, b;
  logic [3:0] sw_addr, flt;
  logic [15:0] sw_wdata, sw_rdata;
  logic [11:0] conv, prev;
  logic [2:0] gain;
  logic [7:0] ofs, refv;
  logic [18:0] addr;
  logic [47:0] c;
  logic [31:0] e;
  logic [22:0] f;
  logic [31:0] rq[$];
  logic [22:0] cq[$];
  int seed = 38686, err_count = 0, checks = 0, cyc = 0, last = 0;
  logic [3:0] fltab [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
  logic [2:0] gtab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  sgpc_link_if link ();
  sgpc_board u_sgpc_board (.core_clk_i(clk), .sys_rst_i(rst), .link(link), .gen_clk_src_i(gen_clk),
    .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata));
  sgpc_card u_sgpc_card (.core_clk_i(clk), .sys_rst_i(rst), .link(link), .converter_word_o(conv),
    .deglitch_sample_strobe_o(strobe), .filter_range_code_o(flt), .amp_gain_code_o(gain),
    .output_offset_value_o(ofs), .converter_reference_value_o(refv), .play_address_o(addr),
    .scan_active_o(scan));
  sgpc_checker u_sgpc_checker (.core_clk_i(clk), .sys_rst_i(rst), .ser_data(link.ser_data),
    .ser_shift(link.ser_shift), .ser_latch(link.ser_latch), .wave_strobe(link.wave_strobe),
    .wave_addr(link.wave_addr), .converter_word_o(conv), .deglitch_sample_strobe_o(strobe),
    .filter_range_code_o(flt), .amp_gain_code_o(gain), .output_offset_value_o(ofs),
    .converter_reference_value_o(refv), .play_address_o(addr), .scan_active_o(scan));
  task conclude;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [15:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are taken at the negedge there.
  task rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] v);
    sw_addr <= a;
    sw_rd <= 1'b1;
    rq.push_back({m, v});
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    b = sw_rdata[15];
    @(posedge clk);
  endtask : rd
  task send(input logic [47:0] x);
    wr(HOST_CTRL_LO, x[15:0]);
    wr(HOST_CTRL_MID, x[31:16]);
    wr(HOST_CTRL_HI, x[47:32]);
    cq.push_back({x[22:20], ((x[DC_LSB] | x[OFF_LSB]) ? FLT_20HZ : x[19:16]), x[15:0]});
    b = 1'b1;
    for (int k = 0; k < 400 && b; k++) rd(HOST_STATUS, 16'h0000, 16'h0000);
  endtask : send
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    gen_clk <= cyc[1];
    rd_d <= sw_rd;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  always @(negedge clk) begin
    if (rd_d) begin
      e = rq.pop_front();
      if (e[31:16] != 16'h0000) check({8'h00, sw_rdata & e[31:16]}, {8'h00, e[15:0]});
    end
    if (chk_scan && conv !== prev) begin
      if (last != 0) begin
        check({12'h000, conv}, {12'h000, 4'ha, prev[7:0] + 8'h01});
        check(24'(cyc - last), 24'h00000c);
        check({23'h0, strobe}, 24'h0);
      end
      last = cyc;
      prev = conv;
    end
  end
  always @(posedge link.ser_latch) begin
    repeat (8) @(negedge clk);
    f = cq.pop_front();
    check({1'b0, gain, flt, ofs, refv}, {1'b0, f});
  end
  initial begin
    rst = 1'b1;
    gen_clk = 1'b0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    chk_scan = 1'b0;
    rd_d = 1'b0;
    prev = 12'h000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({1'b0, gain, flt, ofs, refv}, {1'b0, GAIN_0DB, FLT_20HZ, 16'h0000});
    check({4'h0, addr, scan}, 24'h0);
    @(posedge clk);
    rd(HOST_STATUS, 16'hffff, 16'h0000);
    rd(4'hf, 16'hffff, 16'h0000);
    for (int i = 0; i < 14; i++) begin
      c = CTRL_ZERO;
      c[7:0] = 8'($random(seed));
      c[15:8] = 8'($random(seed));
      c[FLT_LSB+:4] = fltab[i % 12];
      c[GAIN_LSB+:3] = gtab[i % 7];
      c[DC_LSB] = (i == 12);
      c[OFF_LSB] = (i == 13);
      send(c);
    end
    c = CTRL_ZERO;
    c[CLR_LSB] = 1'b1;
    send(c);
    for (int i = 0; i < 256; i++) begin
      wr(HOST_WAVE, {4'($random(seed)), 4'ha, 8'(i)});
      if (i == 99) begin
        repeat (4) @(posedge clk);
        check({5'h00, addr}, 24'h000064);
        rd(HOST_STATUS, 16'h7fff, 16'h0064);
      end
    end
    c[RUN_LSB] = 1'b1;
    c[DIV_LSB+:15] = 15'h0003;
    send(c);
    last = 0;
    chk_scan = 1'b1;
    repeat (3600) @(posedge clk);
    chk_scan = 1'b0;
    check({23'h0, scan}, 24'h1);
    c[SINGLE_LSB] = 1'b1;
    send(c);
    repeat (60) @(posedge clk);
    check({5'h00, addr}, 24'h0);
    c[TRIG_LSB] = 1'b1;
    send(c);
    repeat (200) @(posedge clk);
    check({23'h0, addr === ADDR_ZERO}, 24'h0);
    repeat (3300) @(posedge clk);
    check({5'h00, addr}, 24'h0);
    c[SINGLE_LSB] = 1'b0;
    c[TRIG_LSB] = 1'b0;
    send(c);
    repeat (60) @(posedge clk);
    check({23'h0, scan}, 24'h1);
    // A word loaded in mid-scan must drop the card to processor mode with a zero output.
    wr(HOST_WAVE, 16'h0fff);
    repeat (2) @(negedge clk);
    check({11'h000, conv, scan}, 24'h000000);
    conclude();
  end
endmodule : testbench
